/* File: rtl/ulofs_pkg.sv */
// shared constants and types for the overhead filter and frame sync block
package ulofs_pkg;
  localparam int  CLK_MHZ         = 50;
  localparam int  ACT_TIMEOUT_S   = 15;
  localparam int  ACT_TIMEOUT_CYC = ACT_TIMEOUT_S * CLK_MHZ * 1_000_000;
  localparam int  WAKE_TONE_HZ    = 10_000;
  localparam int  WAKE_HALF_CYC   = CLK_MHZ * 1_000_000 / (2 * WAKE_TONE_HZ);
  localparam real TEST_PULSE_US   = 12.5;
  localparam int  TEST_PULSE_CYC  = int'(TEST_PULSE_US * CLK_MHZ);
  localparam real TEST_GAP_MS     = 1.5;
  localparam int  TEST_GAP_CYC    = int'(TEST_GAP_MS * 1000.0 * CLK_MHZ);
  localparam int  FRAME_DCL       = 768;
  localparam int  SF_FRAMES       = 96;

  localparam logic [7:0] LCMD_FIRST_BYTE = 8'h80;
  localparam logic [7:0] LCMD_M4_BASE    = 8'h8c;
  localparam logic [7:0] LCMD_SPARE_BASE = 8'h88;

  localparam logic [3:0] REG_ADDITIONAL_FUNCTION_REG2       = 4'h0;
  localparam logic [3:0] REG_STATUS     = 4'h4;
  localparam logic [3:0] REG_CTRL       = 4'h8;
  localparam int         ADDITIONAL_FUNCTION_REG2_SUPERFRAME_MARKER_ENABLE_BIT  = 0;
  localparam logic       ADDITIONAL_FUNCTION_REG2_SUPERFRAME_MARKER_ENABLE_RST  = 1'h1;
  localparam int         CTRL_SWRST_BIT = 0;

  localparam logic [1:0] PAY_ONES   = 2'h0;
  localparam logic [1:0] PAY_ZERO   = 2'h1;
  localparam logic [1:0] PAY_NORMAL = 2'h2;
  localparam logic [1:0] SYM_SILENT = 2'h0;
  localparam logic [1:0] SYM_POS    = 2'h1;
  localparam logic [1:0] SYM_NEG    = 2'h3;

  typedef enum logic [1:0] {
    FLT_CHANGE = 2'h0, FLT_CRC = 2'h1, FLT_TLL = 2'h2, FLT_BOTH = 2'h3
  } ulofs_filter_t;
  typedef enum logic [1:0] {
    MODE_LT = 2'h0, MODE_NT = 2'h1, MODE_LT_RP = 2'h2, MODE_NT_RP = 2'h3
  } ulofs_mode_t;
  typedef enum logic [3:0] {
    LS_TEST, LS_DEACT, LS_LINE_ACTIVE, LS_PEND_TRANSP, LS_ST_DEACT, LS_PEND_DEACT,
    LS_TRANSP, LS_SYNC1, LS_SYNC2, LS_WAIT_ACT, LS_ST_ERROR, LS_PEND_DEACT_ST,
    LS_PEND_DEACT_U, LS_ALOOP, LS_SYNC, LS_ERROR
  } ulofs_line_state_t;
  typedef enum logic [1:0] {
    CMD_NONE = 2'h0, CMD_AR = 2'h1, CMD_ARX = 2'h2, CMD_AR0 = 2'h3
  } ulofs_act_cmd_t;
  typedef enum logic [1:0] {
    ACT_DEACT = 2'h0, ACT_AWAIT = 2'h1, ACT_ACTIVE = 2'h3, ACT_ERR = 2'h2
  } ulofs_act_state_t;
  typedef enum logic [2:0] {
    SIG_SILENT, SIG_WAKE, SIG_ACT1, SIG_ACT2, SIG_ACT3, SIG_TRANSP, SIG_TEST
  } ulofs_sig_sel_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] first_byte;
    logic [7:0] code;
  } ulofs_lcmd_t;
  typedef struct packed {
    logic [7:0] m4;
    logic [2:0] spare;
  } ulofs_ovh_t;
  typedef struct packed {
    logic       m4_valid;
    logic       spare_valid;
    ulofs_ovh_t bits;
  } ulofs_report_t;
  typedef struct packed {
    logic       sync_word;
    logic       inv_sync;
    logic [1:0] payload;
    logic       mbits_normal;
    logic [1:0] symbol;
  } ulofs_line_sig_t;

  typedef struct packed {
    logic             dcl_s1, dcl_s2, dcl_d;
    logic             fs_s1, fs_s2, fs_d;
    logic             uvd_s1, uvd_s2;
    logic             in_test, superframe_marker_enable, sw_reset;
    ulofs_filter_t    flt_m4, flt_spare;
    ulofs_ovh_t       hist1, hist2, reported;
    logic [1:0]       crc_hist;
    ulofs_report_t    report;
    logic [1:0]       fs_hi_cnt;
    logic [6:0]       frame_cnt;
    logic             isw_pend, isw_insert, sf_start;
    logic [9:0]       gen_cnt;
    logic             gen_fs, fs_oe;
    ulofs_act_state_t act_state;
    logic [29:0]      act_tmr;
    logic             no_timeout, act_eval, line_active, to_err;
    logic [11:0]      tone_cnt;
    logic             tone_pol;
    logic [16:0]      tp_cnt;
    logic             tp_pol;
    ulofs_line_sig_t  line_sig;
    logic [7:0]       rdata;
  } ulofs_state_t;
endpackage

/* File: rtl/ulofs_core.sv */
// overhead bit filter, frame sync marker and activation start logic
`timescale 1ns/1ns
`default_nettype none

module ulofs_core
  import ulofs_pkg::*;
#(
  parameter int ACT_TIMEOUT = ACT_TIMEOUT_CYC,
  parameter int TEST_GAP    = TEST_GAP_CYC,
  parameter int FRAME_LEN   = FRAME_DCL
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  input  wire ulofs_mode_t       op_mode_i,
  input  wire logic              undervoltage_detect_i,
  input  wire logic              data_clock_i,
  input  wire logic              frame_sync_i,
  input  wire logic              sf_marker_sel_i,
  input  wire ulofs_lcmd_t       local_command_message_i,
  input  wire logic              sf_done_i,
  input  wire ulofs_ovh_t        rx_ovh_i,
  input  wire logic              crc_ok_i,
  input  wire logic              rx_sync_i,
  input  wire ulofs_line_state_t line_state_i,
  input  wire ulofs_act_cmd_t    act_cmd_i,
  input  wire logic              upstream_activation_signal_3_ok_i,
  input  wire logic              act_bit_i,
  input  wire logic              deact_i,
  input  wire ulofs_sig_sel_t    sig_sel_i,
  input  wire logic              sig_down_i,
  input  wire logic [3:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic [7:0]             reg_rdata_o,
  output ulofs_report_t          overhead_bit_report_o,
  output logic                   frame_sync_o,
  output logic                   frame_sync_oe_o,
  output logic                   inverted_sync_word_insert_o,
  output logic                   sf_start_o,
  output logic                   line_active_indication_o,
  output logic                   activation_timeout_error_o,
  output ulofs_line_sig_t        line_sig_o
);

  ulofs_state_t state_reg;
  ulofs_state_t state_next;
  logic         dcl_rise;
  logic         fs_rise;
  logic         fs_fall;
  logic         test_entry;
  logic         nt_side;
  logic         is_rp;
  logic         rep_en;
  logic         crc_good;
  logic         tll_m4;
  logic         tll_sp;
  logic         marker_now;

  function automatic logic flt_pass(ulofs_filter_t f, logic triple_look_filter, logic crc);
    case (f)
      FLT_CHANGE: return 1'b1;
      FLT_CRC:    return crc;
      FLT_TLL:    return triple_look_filter;
      default:    return triple_look_filter & crc;
    endcase
  endfunction

  function automatic logic state_reports(ulofs_mode_t m, ulofs_line_state_t s);
    case (m)
      MODE_LT: return s inside {LS_LINE_ACTIVE, LS_PEND_TRANSP, LS_ST_DEACT,
                                LS_PEND_DEACT, LS_TRANSP};
      MODE_NT: return s inside {LS_SYNC1, LS_SYNC2, LS_WAIT_ACT, LS_TRANSP,
                                LS_ST_ERROR, LS_PEND_DEACT_ST, LS_PEND_DEACT_U,
                                LS_ALOOP};
      MODE_LT_RP: return s inside {LS_PEND_TRANSP, LS_TRANSP, LS_PEND_DEACT};
      default: return s inside {LS_SYNC, LS_TRANSP, LS_ERROR, LS_PEND_DEACT,
                                LS_ALOOP};
    endcase
  endfunction

  // edges come from the second and third flops, never the first
  assign dcl_rise   = state_reg.dcl_s2 & ~state_reg.dcl_d;
  assign fs_rise    = state_reg.fs_s2 & ~state_reg.fs_d;
  assign fs_fall    = ~state_reg.fs_s2 & state_reg.fs_d;
  assign test_entry = state_reg.in_test | state_reg.uvd_s2 | state_reg.sw_reset;
  assign nt_side    = (op_mode_i == MODE_NT) || (op_mode_i == MODE_NT_RP);
  assign is_rp      = (op_mode_i == MODE_LT_RP) || (op_mode_i == MODE_NT_RP);
  assign rep_en     = rx_sync_i && state_reports(op_mode_i, line_state_i);
  assign crc_good   = &state_reg.crc_hist;
  assign tll_m4     = (rx_ovh_i.m4 == state_reg.hist1.m4)
                   && (rx_ovh_i.m4 == state_reg.hist2.m4);
  assign tll_sp     = (rx_ovh_i.spare == state_reg.hist1.spare)
                   && (rx_ovh_i.spare == state_reg.hist2.spare);
  assign marker_now = sf_marker_sel_i && (state_reg.frame_cnt == 7'h00);

  always_comb begin
    state_next        = state_reg;
    state_next.dcl_s1 = data_clock_i;
    state_next.dcl_s2 = state_reg.dcl_s1;
    state_next.dcl_d  = state_reg.dcl_s2;
    state_next.fs_s1  = frame_sync_i;
    state_next.fs_s2  = state_reg.fs_s1;
    state_next.fs_d   = state_reg.fs_s2;
    state_next.uvd_s1 = undervoltage_detect_i;
    state_next.uvd_s2 = state_reg.uvd_s1;
    state_next.in_test  = 1'b0;
    state_next.sw_reset = 1'b0;
    state_next.rdata    = 8'h00;

    // register port, read data only in the cycle after the strobe
    if (reg_wr_i) begin
      case (reg_addr_i)
        REG_ADDITIONAL_FUNCTION_REG2: state_next.superframe_marker_enable     = reg_wdata_i[ADDITIONAL_FUNCTION_REG2_SUPERFRAME_MARKER_ENABLE_BIT];
        REG_CTRL: state_next.sw_reset = reg_wdata_i[CTRL_SWRST_BIT];
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        REG_ADDITIONAL_FUNCTION_REG2:   state_next.rdata = {7'h00, state_reg.superframe_marker_enable};
        REG_STATUS: state_next.rdata = {1'b0, state_reg.isw_pend, state_reg.act_state,
                                        state_reg.flt_spare, state_reg.flt_m4};
        default:    state_next.rdata = 8'h00;
      endcase
    end

    // filter selection by local command, first byte must equal LCMD_FIRST_BYTE
    if (local_command_message_i.valid
        && local_command_message_i.first_byte == LCMD_FIRST_BYTE) begin
      if (local_command_message_i.code[7:2] == LCMD_M4_BASE[7:2]) begin
        state_next.flt_m4 = ulofs_filter_t'(local_command_message_i.code[1:0]);
      end else if (local_command_message_i.code[7:2] == LCMD_SPARE_BASE[7:2]) begin
        state_next.flt_spare = ulofs_filter_t'(local_command_message_i.code[1:0]);
      end
    end

    // overhead filtering once per received superframe
    state_next.report.m4_valid    = 1'b0;
    state_next.report.spare_valid = 1'b0;
    if (sf_done_i) begin
      state_next.hist1    = rx_ovh_i;
      state_next.hist2    = state_reg.hist1;
      state_next.crc_hist = {state_reg.crc_hist[0], crc_ok_i};
      // a blocked change stays pending and is reported once allowed
      if (rep_en && rx_ovh_i.m4 != state_reg.reported.m4
          && flt_pass(state_reg.flt_m4, tll_m4, crc_good)) begin
        state_next.report.m4_valid = 1'b1;
        state_next.reported.m4     = rx_ovh_i.m4;
      end
      if (rep_en && rx_ovh_i.spare != state_reg.reported.spare
          && flt_pass(state_reg.flt_spare, tll_sp, crc_good)) begin
        state_next.report.spare_valid = 1'b1;
        state_next.reported.spare     = rx_ovh_i.spare;
      end
      state_next.report.bits = state_next.reported;
    end

    // frame sync: driven in nt modes, decoded in lt modes
    state_next.isw_insert = 1'b0;
    state_next.sf_start   = 1'b0;
    if (nt_side) begin
      state_next.fs_oe = 1'b1;
      if (dcl_rise) begin
        if (state_reg.gen_cnt == 10'(FRAME_LEN - 1)) begin
          state_next.gen_cnt = 10'h000;
          state_next.gen_fs  = 1'b1;
          if (state_reg.frame_cnt == 7'(SF_FRAMES - 1)) begin
            state_next.frame_cnt = 7'h00;
            state_next.sf_start  = 1'b1;
          end else begin
            state_next.frame_cnt = state_reg.frame_cnt + 7'h01;
          end
        end else begin
          state_next.gen_cnt = state_reg.gen_cnt + 10'h001;
          if (state_reg.gen_cnt == (marker_now ? 10'h000 : 10'h001)) begin
            state_next.gen_fs = 1'b0;
          end
        end
      end
    end else begin
      state_next.fs_oe  = 1'b0;
      state_next.gen_fs = 1'b0;
      if (state_reg.fs_s2 && dcl_rise && state_reg.fs_hi_cnt != 2'h3) begin
        state_next.fs_hi_cnt = state_reg.fs_hi_cnt + 2'h1;
      end
      // the superframe count free-runs, so the offset holds until a marker
      if (fs_rise) begin
        state_next.fs_hi_cnt = 2'h0;
        if (state_reg.isw_pend || state_reg.frame_cnt == 7'(SF_FRAMES - 1)) begin
          state_next.frame_cnt  = 7'h00;
          state_next.isw_insert = 1'b1;
          state_next.sf_start   = 1'b1;
          state_next.isw_pend   = 1'b0;
        end else begin
          state_next.frame_cnt = state_reg.frame_cnt + 7'h01;
        end
      end
      // stray spikes shift the superframe count for good when markers are off
      // the clock edge that opens the pulse is not counted, so 0 means one period
      if (fs_fall && state_reg.fs_hi_cnt == 2'h0 && state_reg.superframe_marker_enable) begin
        state_next.isw_pend = 1'b1;
      end
    end

    // activation start
    case (state_reg.act_state)
      ACT_DEACT: begin
        if (act_cmd_i != CMD_NONE) begin
          state_next.act_state  = ACT_AWAIT;
          state_next.act_tmr    = 30'h0;
          state_next.no_timeout = (act_cmd_i == CMD_ARX);
          state_next.act_eval   = (act_cmd_i != CMD_AR0);
        end
      end
      ACT_AWAIT: begin
        if (state_reg.act_tmr != '1) begin
          state_next.act_tmr = state_reg.act_tmr + 30'h1;
        end
        if (act_cmd_i == CMD_AR0) begin
          state_next.act_eval = 1'b0;
        end
        if (upstream_activation_signal_3_ok_i && (act_bit_i || !state_reg.act_eval)) begin
          state_next.act_state = ACT_ACTIVE;
        end else if (!state_reg.no_timeout
                     && state_reg.act_tmr == 30'(ACT_TIMEOUT - 1)) begin
          state_next.act_state = ACT_ERR;
        end
      end
      ACT_ACTIVE: begin
        if (act_cmd_i == CMD_AR) begin
          state_next.act_eval = 1'b1;
        end
        if (deact_i) begin
          state_next.act_state = ACT_DEACT;
        end
      end
      ACT_ERR: ;
      default: state_next.act_state = ACT_DEACT;
    endcase

    // test state restores mode defaults and drops activation
    if (test_entry) begin
      state_next.flt_m4    = is_rp ? FLT_CRC : FLT_TLL;
      state_next.flt_spare = is_rp ? FLT_CRC : FLT_TLL;
      state_next.act_state = ACT_DEACT;
    end
    state_next.line_active = (state_next.act_state == ACT_ACTIVE);
    state_next.to_err      = (state_next.act_state == ACT_ERR);

    // line signal encoder
    if (state_reg.tone_cnt == 12'(WAKE_HALF_CYC - 1)) begin
      state_next.tone_cnt = 12'h000;
      state_next.tone_pol = ~state_reg.tone_pol;
    end else begin
      state_next.tone_cnt = state_reg.tone_cnt + 12'h001;
    end
    if (state_reg.tp_cnt == 17'(TEST_PULSE_CYC + TEST_GAP - 1)) begin
      state_next.tp_cnt = 17'h00000;
      state_next.tp_pol = ~state_reg.tp_pol;
    end else begin
      state_next.tp_cnt = state_reg.tp_cnt + 17'h00001;
    end
    state_next.line_sig = '0;
    case (sig_sel_i)
      SIG_WAKE: state_next.line_sig.symbol = state_reg.tone_pol ? SYM_NEG : SYM_POS;
      SIG_ACT1: state_next.line_sig.sync_word = 1'b1;
      SIG_ACT2: begin
        state_next.line_sig.sync_word    = 1'b1;
        state_next.line_sig.inv_sync     = sig_down_i;
        state_next.line_sig.payload      = sig_down_i ? PAY_ZERO : PAY_ONES;
        state_next.line_sig.mbits_normal = sig_down_i;
      end
      SIG_ACT3: begin
        state_next.line_sig.sync_word    = 1'b1;
        state_next.line_sig.inv_sync     = 1'b1;
        state_next.line_sig.payload      = sig_down_i ? PAY_ZERO : PAY_ONES;
        state_next.line_sig.mbits_normal = 1'b1;
      end
      SIG_TRANSP: begin
        state_next.line_sig.sync_word    = 1'b1;
        state_next.line_sig.inv_sync     = 1'b1;
        state_next.line_sig.payload      = PAY_NORMAL;
        state_next.line_sig.mbits_normal = 1'b1;
      end
      SIG_TEST: begin
        if (state_reg.tp_cnt < 17'(TEST_PULSE_CYC)) begin
          state_next.line_sig.symbol = state_reg.tp_pol ? SYM_NEG : SYM_POS;
        end
      end
      default: state_next.line_sig = '0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_reg           <= '0;
      state_reg.in_test   <= 1'b1;
      state_reg.superframe_marker_enable      <= ADDITIONAL_FUNCTION_REG2_SUPERFRAME_MARKER_ENABLE_RST;
      state_reg.flt_m4    <= FLT_TLL;
      state_reg.flt_spare <= FLT_TLL;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata_o                 = state_reg.rdata;
  assign overhead_bit_report_o       = state_reg.report;
  assign frame_sync_o                = state_reg.gen_fs;
  assign frame_sync_oe_o             = state_reg.fs_oe;
  assign inverted_sync_word_insert_o = state_reg.isw_insert;
  assign sf_start_o                  = state_reg.sf_start;
  assign line_active_indication_o    = state_reg.line_active;
  assign activation_timeout_error_o  = state_reg.to_err;
  assign line_sig_o                  = state_reg.line_sig;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_tll_blocks_m4: assert property (
    (sf_done_i && state_reg.flt_m4 == FLT_TLL && !tll_m4) |=> !overhead_bit_report_o.m4_valid)
    else $error("status group reported without triple look");
  a_crc_blocks_m4: assert property (
    (sf_done_i && state_reg.flt_m4 == FLT_CRC && !crc_good) |=> !overhead_bit_report_o.m4_valid)
    else $error("status group reported with bad crc history");
  a_both_blocks_m4: assert property (
    (sf_done_i && state_reg.flt_m4 == FLT_BOTH && !(tll_m4 && crc_good))
    |=> !overhead_bit_report_o.m4_valid)
    else $error("combined filter let a status change through");
  a_change_reports_sp: assert property (
    (sf_done_i && rep_en && state_reg.flt_spare == FLT_CHANGE
     && rx_ovh_i.spare != state_reg.reported.spare)
    |=> overhead_bit_report_o.spare_valid && overhead_bit_report_o.bits.spare == $past(rx_ovh_i.spare))
    else $error("unfiltered spare change not reported");
  a_no_rep_unsync: assert property (
    (overhead_bit_report_o.m4_valid || overhead_bit_report_o.spare_valid) |-> $past(rep_en))
    else $error("report outside synchronized reporting states");
  a_uvd_defaults: assert property (
    (state_reg.uvd_s2 && !is_rp) |=> state_reg.flt_m4 == FLT_TLL && state_reg.flt_spare == FLT_TLL)
    else $error("filter settings not restored on undervoltage");
  a_nt_marker_short: assert property (
    (nt_side && dcl_rise && state_reg.gen_fs && state_reg.gen_cnt == 10'h000 && marker_now)
    |=> !frame_sync_o)
    else $error("superframe marker longer than one period");
  a_short_pulse_pend: assert property (
    (!nt_side && fs_fall && state_reg.fs_hi_cnt == 2'h0 && state_reg.superframe_marker_enable) |=> state_reg.isw_pend)
    else $error("short sync pulse not taken as marker");
  a_superframe_marker_enable_off_ignores: assert property (
    !state_reg.superframe_marker_enable |=> !$rose(state_reg.isw_pend))
    else $error("marker taken while marker enable is clear");
  a_timeout_at_limit: assert property (
    (state_reg.act_state == ACT_AWAIT && !state_reg.no_timeout && !test_entry
     && state_reg.act_tmr == 30'(ACT_TIMEOUT - 1) && !upstream_activation_signal_3_ok_i)
    |=> ##1 activation_timeout_error_o)
    else $error("activation timeout error missing");
  a_arx_no_timeout: assert property (
    (state_reg.act_state == ACT_AWAIT && state_reg.no_timeout) |=> !state_reg.to_err)
    else $error("extended activation timed out");

  c_m4_report:   cover property (overhead_bit_report_o.m4_valid);
  c_isw_insert:  cover property (inverted_sync_word_insert_o);
  c_line_active: cover property ($rose(line_active_indication_o));
  c_timeout:     cover property ($rose(activation_timeout_error_o));

endmodule

`default_nettype wire

/* File: verification/ulofs_ctrl_model.sv */
// controller side model: data clock and frame sync of the serial bus
`timescale 1ns/1ns
`default_nettype none
module ulofs_ctrl_model #(
  parameter int FRAME_LEN = 8
) (
  input  wire logic short_i,
  output logic      data_clock_o,
  output logic      frame_sync_o
);
  // clock runs free: frames follow each other with no gap
  initial begin
    data_clock_o = 1'h0;
    frame_sync_o = 1'h0;
    #7;
    forever begin
      for (int i = 0; i < FRAME_LEN; i++) begin
        frame_sync_o = (i == 0) || (i == 1 && !short_i);
        data_clock_o = 1'h1;
        #80 data_clock_o = 1'h0;
        #80;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/ulofs_core_tb.sv */
// self-checking bench for the overhead filter and frame sync block
`timescale 1ns/1ns
`default_nettype none
module ulofs_core_tb;
  import ulofs_pkg::*;
  localparam int TGAP = 100;
  // sel, down, mask, expected
  localparam logic [17:0] SIGR [8] = '{{3'h0, 1'h0, 7'h63, 7'h00}, {3'h2, 1'h0, 7'h7c, 7'h40},
    {3'h3, 1'h0, 7'h7c, 7'h40}, {3'h4, 1'h0, 7'h7c, 7'h64}, {3'h5, 1'h0, 7'h7c, 7'h74},
    {3'h2, 1'h1, 7'h7c, 7'h40}, {3'h3, 1'h1, 7'h7c, 7'h6c}, {3'h0, 1'h1, 7'h63, 7'h00}};
  // code, status bits, crc good, report expected
  localparam logic [17:0] SFR [10] = '{{8'h8c, 8'h11, 2'h1}, {8'h8e, 8'h44, 2'h0},
    {8'h8e, 8'h44, 2'h0}, {8'h8e, 8'h44, 2'h1}, {8'h8d, 8'h55, 2'h2}, {8'h8d, 8'h66, 2'h2},
    {8'h8d, 8'h77, 2'h1}, {8'h8f, 8'h88, 2'h2}, {8'h8f, 8'h88, 2'h2}, {8'h8f, 8'h88, 2'h3}};
  logic              clk = 1'h0, rst_n = 1'h0, sf_done = 1'h0, crc_ok = 1'h0, rx_sync = 1'h1;
  logic              undervoltage_detect = 1'h0, shrt = 1'h0, sn3 = 1'h0, actb = 1'h0, sdown = 1'h0;
  logic              wr = 1'h0, rd = 1'h0, data_clock, fsync, inverted_sync_word, lact, terr, seen, gfs, gfoe, sfs;
  logic              deact = 1'h0, bad = 1'h0;
  ulofs_lcmd_t       lcmd = '0;
  ulofs_ovh_t        ovh = '0;
  ulofs_line_state_t lst = LS_LINE_ACTIVE;
  ulofs_act_cmd_t    cmd = CMD_NONE;
  ulofs_sig_sel_t    ssel = SIG_SILENT;
  logic [3:0]        addr = 4'h0;
  logic [7:0]        wd = 8'h0, rdata, d;
  ulofs_report_t     rep;
  ulofs_line_sig_t   lsig;
  int                n_fail = 0, n_tests = 0, n;
  always #10 clk = ~clk;
  ulofs_ctrl_model #(.FRAME_LEN(8)) ctrl_u (.short_i(shrt), .data_clock_o(data_clock),
    .frame_sync_o(fsync));
  ulofs_core #(.ACT_TIMEOUT(200), .TEST_GAP(TGAP), .FRAME_LEN(8)) dut_u (.sys_clk_i(clk),
    .rst_n_i(rst_n), .op_mode_i(MODE_LT), .undervoltage_detect_i(undervoltage_detect), .data_clock_i(data_clock),
    .frame_sync_i(fsync), .sf_marker_sel_i(1'h0), .local_command_message_i(lcmd),
    .sf_done_i(sf_done), .rx_ovh_i(ovh), .crc_ok_i(crc_ok), .rx_sync_i(rx_sync),
    .line_state_i(lst), .act_cmd_i(cmd), .upstream_activation_signal_3_ok_i(sn3),
    .act_bit_i(actb), .deact_i(deact), .sig_sel_i(ssel), .sig_down_i(sdown),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .overhead_bit_report_o(rep), .frame_sync_o(gfs), .frame_sync_oe_o(gfoe),
    .inverted_sync_word_insert_o(inverted_sync_word), .sf_start_o(sfs), .line_active_indication_o(lact),
    .activation_timeout_error_o(terr), .line_sig_o(lsig));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wd   <= v;
    wr   <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  // returns on a clock edge so callers drive at the edge
  task automatic rreg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  task automatic lc(input logic [7:0] fb, input logic [7:0] c);
    @(posedge clk);
    lcmd <= {1'h1, fb, c};
    @(posedge clk);
    lcmd <= '0;
  endtask
  task automatic sfx(input logic [7:0] m, input logic ok, output logic s);
    @(posedge clk);
    sf_done <= 1'h1;
    ovh     <= {m, 3'h5};
    crc_ok  <= ok;
    @(posedge clk);
    sf_done <= 1'h0;
    s = 1'h0;
    repeat (3) begin
      #1 s |= rep.m4_valid;
      @(posedge clk);
    end
  endtask
  // optional short frame sync pulse, then watch for the superframe restart
  task automatic shortp(input logic p, output logic s);
    @(posedge clk);
    shrt <= p;
    s = 1'h0;
    for (int i = 0; i < 220; i++) begin
      @(posedge clk);
      if (i == 64) shrt <= 1'h0;
      #1 s |= inverted_sync_word;
      bad |= gfs | gfoe | (inverted_sync_word ^ sfs);
    end
  endtask
  // +3 counts 1 and -3 counts 1000, over whole periods
  task automatic symc(input ulofs_sig_sel_t sel, input int len, output int c);
    @(posedge clk);
    ssel <= sel;
    repeat (2) @(posedge clk);
    c = 0;
    repeat (len) begin
      #1 c += (lsig.symbol == SYM_POS) ? 1 : ((lsig.symbol == SYM_NEG) ? 1000 : 0);
      @(posedge clk);
    end
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #400_000;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    rreg(REG_STATUS, d);
    chk("status", 8'h0a, d & 8'h3f);
    rreg(REG_ADDITIONAL_FUNCTION_REG2, d);
    chk("additional_function_reg2", 8'h01, d);
    rreg(4'hc, d);
    chk("unmapped", 8'h00, d);
    for (int i = 0; i < 8; i++) begin
      lc(8'h80, 8'h88 + 8'(i));
      rreg(REG_STATUS, d);
      chk("flt", (i < 4) ? {4'h0, 2'(i), 2'h2} : {4'h0, 2'h3, 2'(i)}, d & 8'h0f);
    end
    lc(8'h88, 8'h8c);
    lc(8'h80, 8'h90);
    rreg(REG_STATUS, d);
    chk("refused", 8'h0f, d & 8'h0f);
    foreach (SIGR[i]) begin
      @(posedge clk);
      ssel  <= ulofs_sig_sel_t'(SIGR[i][17:15]);
      sdown <= SIGR[i][14];
      repeat (2) @(posedge clk);
      #1 chk("sig", {1'h0, SIGR[i][6:0]}, {1'h0, lsig & SIGR[i][13:7]});
    end
    foreach (SFR[i]) begin
      lc(8'h80, SFR[i][17:10]);
      sfx(SFR[i][9:2], SFR[i][1], seen);
      chk("rep", {7'h0, SFR[i][0]}, {7'h0, seen});
    end
    lc(8'h80, 8'h8c);
    rx_sync <= 1'h0;
    sfx(8'h99, 1'h1, seen);
    chk("unsync", 8'h00, {7'h0, seen});
    rx_sync <= 1'h1;
    lst     <= LS_DEACT;
    sfx(8'haa, 1'h1, seen);
    chk("gate", 8'h00, {7'h0, seen});
    lst <= LS_LINE_ACTIVE;
    sfx(8'haa, 1'h1, seen);
    chk("held", 8'haa, seen ? rep.bits.m4 : 8'h00);
    cmd <= CMD_AR;
    for (n = 0; n < 300 && terr !== 1'h1; n++) @(posedge clk);
    chk("tmo", 8'h01, {7'h0, terr & !lact & (n > 190)});
    rreg(REG_STATUS, d);
    chk("err", 8'h20, d & 8'h30);
    cmd <= CMD_NONE;
    wreg(REG_CTRL, 8'h01);
    repeat (3) @(posedge clk);
    cmd <= CMD_ARX;
    repeat (400) @(posedge clk);
    chk("arx", 8'h00, {7'h0, terr});
    sn3  <= 1'h1;
    actb <= 1'h1;
    repeat (4) @(posedge clk);
    #1 chk("act", 8'h01, {7'h0, lact});
    @(posedge clk);
    cmd  <= CMD_NONE;
    actb <= 1'h0;
    wreg(REG_CTRL, 8'h01);
    repeat (3) @(posedge clk);
    cmd <= CMD_AR0;
    repeat (4) @(posedge clk);
    #1 chk("ar0", 8'h01, {7'h0, lact});
    @(posedge clk);
    cmd   <= CMD_NONE;
    deact <= 1'h1;
    repeat (3) @(posedge clk);
    #1 chk("deact", 8'h00, {7'h0, lact});
    @(posedge clk);
    deact <= 1'h0;
    cmd   <= CMD_AR;
    repeat (3) @(posedge clk);
    rreg(REG_STATUS, d);
    chk("act_bit", 8'h10, d & 8'h30);
    lc(8'h80, 8'h8d);
    @(posedge clk);
    undervoltage_detect <= 1'h1;
    cmd <= CMD_NONE;
    repeat (5) @(posedge clk);
    undervoltage_detect <= 1'h0;
    rreg(REG_STATUS, d);
    chk("uvd", 8'h0a, d & 8'h3f);
    shortp(1'h1, seen);
    chk("isw", 8'h01, {7'h0, seen});
    shortp(1'h0, seen);
    chk("long", 8'h00, {7'h0, seen});
    wreg(REG_ADDITIONAL_FUNCTION_REG2, 8'h00);
    shortp(1'h1, seen);
    chk("superframe_marker_enable", 8'h00, {7'h0, seen});
    chk("lt_fs", 8'h00, {7'h0, bad});
    symc(SIG_WAKE, 2 * WAKE_HALF_CYC, n);
    chk("wake", 8'h01, {7'h0, n == 1001 * WAKE_HALF_CYC});
    symc(SIG_TEST, 2 * (TEST_PULSE_CYC + TGAP), n);
    chk("test_pulse", 8'h01, {7'h0, n == 1001 * TEST_PULSE_CYC});
    wrap_up();
  end
endmodule
`default_nettype wire
